// *** bench/dac_clear_control_test.sv ***
// Self-checking testbench for the DAC clear control block
`timescale 1ns/1ps
module dac_clear_control_test;
   // ****************************************
   // Signals, rows and design
   // ****************************************
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000, dat_o, rd;
   logic ack_o, n0 = 1'b1, n1 = 1'b1;
   logic [15:0] alm = 16'h0000;
   logic [143:0] data_i = '0, latch_o;
   logic [11:0] clr_o;
   int n_fail = 0, total_checks = 0;
   typedef struct {logic [15:0] src; logic [11:0] aut, sw, p0, p1; logic [15:0] alm;
      logic n0, n1; logic [11:0] exp;} row_t;
   // Channel masks below are in channel order; bit n is channel n
   row_t rows [10] = '{
      '{16'h0004, 12'h000, 12'h000, 12'h000, 12'h000, 16'h0004, 1'b1, 1'b1, 12'hFFF},
      '{16'h0000, 12'hFFF, 12'h000, 12'h000, 12'h000, 16'h0004, 1'b1, 1'b1, 12'h000},
      '{16'h0008, 12'h0A5, 12'h000, 12'h000, 12'h000, 16'h0008, 1'b1, 1'b1, 12'h0A5},
      '{16'h0004, 12'h0A5, 12'h000, 12'h000, 12'h000, 16'h0008, 1'b1, 1'b1, 12'h000},
      '{16'h4000, 12'h030, 12'h000, 12'h000, 12'h000, 16'h4000, 1'b1, 1'b1, 12'h030},
      '{16'h0000, 12'h000, 12'h801, 12'h00F, 12'hF00, 16'h0000, 1'b1, 1'b1, 12'h801},
      '{16'h0000, 12'h000, 12'h000, 12'h00F, 12'hF00, 16'h0000, 1'b0, 1'b1, 12'h00F},
      '{16'h0000, 12'h000, 12'h000, 12'h00F, 12'hF00, 16'h0000, 1'b1, 1'b0, 12'hF00},
      '{16'h0008, 12'h001, 12'h002, 12'h004, 12'h800, 16'hFFF8, 1'b0, 1'b0, 12'h807},
      '{16'h0000, 12'h000, 12'h000, 12'h000, 12'h000, 16'h0000, 1'b1, 1'b1, 12'h000}
   };
   dac_clear_control uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .alarm_flags_i(alm), .hardware_clear_pin0_n_i(n0), .hardware_clear_pin1_n_i(n1),
      .dac_data_i(data_i), .dac_clear_o(clr_o), .dac_latch_o(latch_o));
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   // ****************************************
   // Tasks and main sequence
   // ****************************************
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Channel n sits at register bit 14-n
   function automatic logic [15:0] to_field(input logic [11:0] c);
      to_field = 16'h0000;
      for (int n = 0; n < 12; n++) to_field[14-n] = c[n];
   endfunction
   // One classic cycle; waits for ack, bounded
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
      int i;
      i = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'h3;
      dat_i <= {16'h0000, d};
      do begin
         @(posedge clk_i);
         i++;
      end while (ack_o !== 1'b1 && i < 20);
      if (ack_o !== 1'b1) begin
         n_fail++;
         $display("BAD at %0t: no acknowledge", $time);
         stop_test();
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask
   initial begin
      for (int n = 0; n < 12; n++) data_i[n*12 +: 12] = 12'hA50 + 12'(n);
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, dac_clear_pkg::SRC_SEL_IDX, 16'h0000);
      chk(rd, 32'h0000_0004);
      for (int a = dac_clear_pkg::AUTO_EN_IDX; a <= dac_clear_pkg::SYNC_CFG_IDX; a++) begin
         bus(1'b0, 8'(a), 16'h0000);
         chk(rd, 32'h0000_0000);
      end
      bus(1'b0, 8'h20, 16'h0000);
      chk(rd, 32'h0000_0000);
      foreach (rows[k]) begin
         bus(1'b1, dac_clear_pkg::SRC_SEL_IDX, rows[k].src);
         bus(1'b1, dac_clear_pkg::AUTO_EN_IDX, to_field(rows[k].aut));
         bus(1'b1, dac_clear_pkg::SW_CLR_IDX, to_field(rows[k].sw));
         bus(1'b1, dac_clear_pkg::PIN0_EN_IDX, to_field(rows[k].p0));
         bus(1'b1, dac_clear_pkg::PIN1_EN_IDX, to_field(rows[k].p1));
         alm <= rows[k].alm;
         n0 <= rows[k].n0;
         n1 <= rows[k].n1;
         repeat (5) @(posedge clk_i);
         chk({20'h0_0000, clr_o}, {20'h0_0000, rows[k].exp});
      end
      bus(1'b1, dac_clear_pkg::AUTO_EN_IDX, 16'hFFFF);
      bus(1'b0, dac_clear_pkg::AUTO_EN_IDX, 16'h0000);
      chk(rd, 32'h0000_7FF8);
      // Latches stay at zero until a strobe, and only enabled channels load
      bus(1'b1, dac_clear_pkg::SYNC_CFG_IDX, 16'h0005);
      chk({20'h0_0000, latch_o[11:0]}, 32'h0000_0000);
      bus(1'b1, dac_clear_pkg::LOAD_CTL_IDX, 16'h0001);
      repeat (3) @(posedge clk_i);
      chk({20'h0_0000, latch_o[35:24]}, 32'h0000_0A52);
      chk({8'h00, latch_o[23:0]}, 32'h0000_0A50);
      data_i[11:0] <= 12'h123;
      repeat (3) @(posedge clk_i);
      chk({20'h0_0000, latch_o[11:0]}, 32'h0000_0A50);
      // Reset in mid-run drops a software clear and restores the source select
      bus(1'b1, dac_clear_pkg::SW_CLR_IDX, to_field(12'hFFF));
      chk({20'h0_0000, clr_o}, 32'h0000_0FFF);
      bus(1'b0, dac_clear_pkg::STATE_IDX, 16'h0000);
      chk(rd, 32'h0000_0FFF);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({20'h0_0000, clr_o}, 32'h0000_0000);
      bus(1'b0, dac_clear_pkg::SRC_SEL_IDX, 16'h0000);
      chk(rd, 32'h0000_0004);
      stop_test();
   end
endmodule // dac_clear_control_test

// *** verilog/dac_clear_control.sv ***
// DAC clear control: clear-source selection, per-channel masks and synchronous load
// ****************************************
// ****************************************
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
module dac_clear_control #(
   parameter int DATA_W = 12
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Alarm flags from the alarm logic (same clock)
   input wire logic [15:0] alarm_flags_i,
   // Hardware clear pins, active low, asynchronous
   input wire logic hardware_clear_pin0_n_i,
   input wire logic hardware_clear_pin1_n_i,
   // DAC channel data and latches
   input wire logic [12*DATA_W-1:0] dac_data_i,
   output logic [11:0] dac_clear_o,
   output logic [12*DATA_W-1:0] dac_latch_o
);
   // ****************************************
   // Registers
   // ****************************************
   logic [15:0] src_sel_q;
   logic [15:0] auto_en_q;
   logic [15:0] sw_clr_q;
   logic [15:0] pin0_en_q;
   logic [15:0] pin1_en_q;
   logic [15:0] sync_cfg_q;
   logic pin0_meta_q;
   logic pin0_sync_q;
   logic pin1_meta_q;
   logic pin1_sync_q;
   logic load_pend_q;

   // Channel n sits at bit 14-n of a 16-bit field
   function automatic logic [11:0] field_to_ch(input logic [15:0] f);
      logic [11:0] c;
      c = '0;
      for (int n = 0; n < 12; n++) begin
         c[n] = f[dac_clear_pkg::CH_MSB - n];
      end
      return c;
   endfunction

   // Sel-aware write merge, low half of the word only
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
         input logic [3:0] s, input logic [15:0] m);
      logic [15:0] n;
      n = old;
      if (s[0]) n[7:0] = d[7:0];
      if (s[1]) n[15:8] = d[15:8];
      return n & m;
   endfunction

   // One channel bit spread over that channel's whole latch word
   function automatic logic [12*DATA_W-1:0] lane_mask(input logic [11:0] en);
      logic [12*DATA_W-1:0] m;
      m = '0;
      for (int n = 0; n < 12; n++) begin
         m[n*DATA_W +: DATA_W] = {DATA_W{en[n]}};
      end
      return m;
   endfunction

   // ****************************************
   // Bus decode
   // ****************************************
   wire logic req = cyc_i && stb_i && !ack_o;
   wire logic wr = req && we_i;
   wire logic wr_src = wr && adr_i == dac_clear_pkg::SRC_SEL_IDX;
   wire logic wr_auto = wr && adr_i == dac_clear_pkg::AUTO_EN_IDX;
   wire logic wr_sw = wr && adr_i == dac_clear_pkg::SW_CLR_IDX;
   wire logic wr_p0 = wr && adr_i == dac_clear_pkg::PIN0_EN_IDX;
   wire logic wr_p1 = wr && adr_i == dac_clear_pkg::PIN1_EN_IDX;
   wire logic wr_sync = wr && adr_i == dac_clear_pkg::SYNC_CFG_IDX;
   wire logic load_strobe = wr && adr_i == dac_clear_pkg::LOAD_CTL_IDX && sel_i[0] && dat_i[0];

   // ****************************************
   // Clear combination
   // ****************************************
   wire logic [11:0] auto_ch = field_to_ch(auto_en_q);
   // Deselected sources contribute nothing; only flags with select=1 count
   wire logic [15:0] active_src = src_sel_q & alarm_flags_i;
   wire logic other_alarm = |(active_src & ~(16'h0001 << dac_clear_pkg::THERMAL_BIT));
   wire logic therm_alarm = active_src[dac_clear_pkg::THERMAL_BIT];
   wire logic [11:0] alarm_clr = (other_alarm ? auto_ch : 12'h000)
      | {12{therm_alarm}};
   wire logic [11:0] sw_clr = field_to_ch(sw_clr_q);
   wire logic [11:0] p0_clr = pin0_sync_q ? 12'h000 : field_to_ch(pin0_en_q);
   wire logic [11:0] p1_clr = pin1_sync_q ? 12'h000 : field_to_ch(pin1_en_q);
   wire logic [11:0] clear_d = alarm_clr | sw_clr | p0_clr | p1_clr;
   // Every channel that some mask lets a clear reach; used by the checks
   wire logic [11:0] maskable_ch = auto_ch | sw_clr | field_to_ch(pin0_en_q)
      | field_to_ch(pin1_en_q);

   // ****************************************
   // Read mux
   // ****************************************
   logic [15:0] rd_word;
   always_comb begin
      unique case (adr_i)
         dac_clear_pkg::SRC_SEL_IDX: rd_word = src_sel_q;
         dac_clear_pkg::AUTO_EN_IDX: rd_word = auto_en_q;
         dac_clear_pkg::SW_CLR_IDX: rd_word = sw_clr_q;
         dac_clear_pkg::PIN0_EN_IDX: rd_word = pin0_en_q;
         dac_clear_pkg::PIN1_EN_IDX: rd_word = pin1_en_q;
         dac_clear_pkg::SYNC_CFG_IDX: rd_word = sync_cfg_q;
         dac_clear_pkg::STATE_IDX: rd_word = {4'h0, dac_clear_o};
         default: rd_word = 16'h0000;
      endcase
   end

   // ****************************************
   // Sequential logic
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= '0;
      end else begin
         ack_o <= req;
         dat_o <= (req && !we_i) ? {16'h0000, rd_word} : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_sel_q <= dac_clear_pkg::SRC_SEL_RST;
         auto_en_q <= dac_clear_pkg::MASK_RST;
         sw_clr_q <= dac_clear_pkg::MASK_RST;
         pin0_en_q <= dac_clear_pkg::MASK_RST;
         pin1_en_q <= dac_clear_pkg::MASK_RST;
         sync_cfg_q <= dac_clear_pkg::MASK_RST;
      end else begin
         if (wr_src) src_sel_q <= merge(src_sel_q, dat_i, sel_i, dac_clear_pkg::SRC_RW_MASK);
         if (wr_auto) auto_en_q <= merge(auto_en_q, dat_i, sel_i, dac_clear_pkg::CH_FIELD_MASK);
         if (wr_sw) sw_clr_q <= merge(sw_clr_q, dat_i, sel_i, dac_clear_pkg::CH_FIELD_MASK);
         if (wr_p0) pin0_en_q <= merge(pin0_en_q, dat_i, sel_i, dac_clear_pkg::CH_FIELD_MASK);
         if (wr_p1) pin1_en_q <= merge(pin1_en_q, dat_i, sel_i, dac_clear_pkg::CH_FIELD_MASK);
         if (wr_sync) sync_cfg_q <= merge(sync_cfg_q, dat_i, sel_i, dac_clear_pkg::SYNC_RW_MASK);
      end
   end

   // Pins are asynchronous: two flops, idle high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin0_meta_q <= 1'b1;
         pin0_sync_q <= 1'b1;
         pin1_meta_q <= 1'b1;
         pin1_sync_q <= 1'b1;
      end else begin
         pin0_meta_q <= hardware_clear_pin0_n_i;
         pin0_sync_q <= pin0_meta_q;
         pin1_meta_q <= hardware_clear_pin1_n_i;
         pin1_sync_q <= pin1_meta_q;
      end
   end

   // Clear goes out one cycle after its cause (three after a pin, via the two sync flops), never waiting for a load
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dac_clear_o <= 12'h000;
         load_pend_q <= 1'b0;
      end else begin
         dac_clear_o <= clear_d;
         load_pend_q <= load_strobe;
      end
   end

   // Latches move only on the load strobe; data writes alone do nothing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dac_latch_o <= '0;
      end else if (load_pend_q) begin
         for (int n = 0; n < 12; n++) begin
            if (sync_cfg_q[n]) begin
               dac_latch_o[n*DATA_W +: DATA_W] <= dac_data_i[n*DATA_W +: DATA_W];
            end
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   chk_therm_all_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (src_sel_q[2] && alarm_flags_i[2]) |=> (dac_clear_o == 12'hFFF))
      else $error("thermal alarm did not clear all channels");
   chk_deselect_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      (src_sel_q == 16'h0000 && sw_clr_q == 16'h0000 && pin0_sync_q && pin1_sync_q)
      |=> (dac_clear_o == 12'h000))
      else $error("clear without any active source");
   chk_sensor2_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (src_sel_q[3] && alarm_flags_i[3]) |=> ((dac_clear_o & $past(auto_ch)) == $past(auto_ch)))
      else $error("sensor2 fail did not clear enabled channels");
   chk_sw_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> ((dac_clear_o & $past(sw_clr)) == $past(sw_clr)))
      else $error("software clear not applied");
   chk_pin0_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (!hardware_clear_pin0_n_i [*3]) |=> ((dac_clear_o & field_to_ch($past(pin0_en_q))) ==
      field_to_ch($past(pin0_en_q))))
      else $error("pin0 clear not applied");
   chk_pin1_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (!hardware_clear_pin1_n_i [*3]) |=> ((dac_clear_o & field_to_ch($past(pin1_en_q))) ==
      field_to_ch($past(pin1_en_q))))
      else $error("pin1 clear not applied");
   chk_reset_thermal: assert property (@(posedge clk_i)
      ($past(rst_i) && !rst_i) |-> src_sel_q == dac_clear_pkg::SRC_SEL_RST)
      else $error("thermal select not set after reset");
   chk_load_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (!load_pend_q) |=> $stable(dac_latch_o))
      else $error("latch changed without load strobe");
   // Load checks compare with inputs (copy check) or latches (skip check) one edge back, when the copy was made
   chk_latch_copy: assert property (@(posedge clk_i) disable iff (rst_i)
      load_pend_q |=> (((dac_latch_o ^ $past(dac_data_i))
      & lane_mask($past(sync_cfg_q[11:0]))) == '0))
      else $error("enabled channel not loaded on strobe");
   chk_latch_skip: assert property (@(posedge clk_i) disable iff (rst_i)
      load_pend_q |=> (((dac_latch_o ^ $past(dac_latch_o))
      & ~lane_mask($past(sync_cfg_q[11:0]))) == '0))
      else $error("disabled channel loaded on strobe");
   chk_strobe_single: assert property (@(posedge clk_i) disable iff (rst_i)
      load_pend_q |=> !load_pend_q)
      else $error("load strobe repeated for one write");
   // A clear outside every mask points to a wrong field-to-channel map
   chk_mask_only: assert property (@(posedge clk_i) disable iff (rst_i)
      !(src_sel_q[dac_clear_pkg::THERMAL_BIT] && alarm_flags_i[dac_clear_pkg::THERMAL_BIT])
      |=> ((dac_clear_o & ~$past(maskable_ch)) == 12'h000))
      else $error("channel cleared outside every enable mask");
   chk_therm_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      (alarm_flags_i[dac_clear_pkg::THERMAL_BIT] && !src_sel_q[dac_clear_pkg::THERMAL_BIT]
      && (src_sel_q & alarm_flags_i) == 16'h0000 && sw_clr_q == 16'h0000
      && pin0_sync_q && pin1_sync_q) |=> (dac_clear_o == 12'h000))
      else $error("deselected thermal alarm cleared a channel");
   chk_unselected_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      ((src_sel_q & alarm_flags_i) == 16'h0000 && sw_clr_q == 16'h0000
      && pin0_sync_q && pin1_sync_q) |=> (dac_clear_o == 12'h000))
      else $error("unselected alarm cleared a channel");
   chk_sw_restore: assert property (@(posedge clk_i) disable iff (rst_i)
      (src_sel_q == 16'h0000 && pin0_sync_q && pin1_sync_q)
      |=> ((dac_clear_o & ~$past(sw_clr)) == 12'h000))
      else $error("software clear held after bit returned to zero");
   chk_first_channel: assert property (@(posedge clk_i) disable iff (rst_i)
      sw_clr_q[dac_clear_pkg::CH_MSB] |=> dac_clear_o[0])
      else $error("field bit 14 did not clear channel 0");
   chk_last_channel: assert property (@(posedge clk_i) disable iff (rst_i)
      sw_clr_q[dac_clear_pkg::CH_LSB] |=> dac_clear_o[11])
      else $error("field bit 3 did not clear channel 11");
   chk_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (((auto_en_q | sw_clr_q | pin0_en_q | pin1_en_q) & ~dac_clear_pkg::CH_FIELD_MASK)
      == 16'h0000))
      else $error("reserved mask bits set");
   chk_source_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
      ((src_sel_q & ~dac_clear_pkg::SRC_RW_MASK) == 16'h0000)
      && ((sync_cfg_q & ~dac_clear_pkg::SYNC_RW_MASK) == 16'h0000))
      else $error("reserved select or sync-load bits set");

   // ****************************************
   // Bus contract checks
   // ****************************************
   chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("acknowledge longer than one cycle");
   chk_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o)
      else $error("request not acknowledged in one cycle");
   chk_ack_cause: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |-> $past(cyc_i && stb_i))
      else $error("acknowledge without a request");
   chk_read_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !ack_o |-> (dat_o == 32'h0000_0000))
      else $error("read data shown without acknowledge");
   chk_write_silent: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && we_i && !ack_o) |=> (dat_o == 32'h0000_0000))
      else $error("write returned read data");
   chk_state_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !we_i && !ack_o && adr_i == dac_clear_pkg::STATE_IDX)
      |=> (dat_o == {20'h0_0000, $past(dac_clear_o)}))
      else $error("clear state read back wrong");
endmodule // dac_clear_control

// *** verilog/dac_clear_pkg.sv ***
// Package: register map, field layout and reset values for the DAC clear control
package dac_clear_pkg;
   // ****************************************
   // Register offsets (printed offsets are word indices)
   // ****************************************
   localparam logic [7:0] SRC_SEL_IDX = 8'h53;
   localparam logic [7:0] AUTO_EN_IDX = 8'h54;
   localparam logic [7:0] SW_CLR_IDX = 8'h55;
   localparam logic [7:0] PIN0_EN_IDX = 8'h56;
   localparam logic [7:0] PIN1_EN_IDX = 8'h57;
   localparam logic [7:0] SYNC_CFG_IDX = 8'h58;
   localparam logic [7:0] LOAD_CTL_IDX = 8'h70;
   localparam logic [7:0] STATE_IDX = 8'h71;
   // ****************************************
   // Field layout and reset values
   // ****************************************
   localparam int NUM_CH = 12;
   localparam int CH_MSB = 14;
   localparam int CH_LSB = 3;
   localparam int SENSOR2_FAIL_BIT = 3;
   localparam int THERMAL_BIT = 2;
   localparam int SRC_MSB = 14;
   localparam int SRC_LSB = 2;
   localparam logic [15:0] SRC_SEL_RST = 16'h0004;
   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam logic [15:0] SRC_RW_MASK = 16'h7FFC;
   localparam logic [15:0] CH_FIELD_MASK = 16'h7FF8;
   localparam logic [15:0] SYNC_RW_MASK = 16'h0FFF;
endpackage
